// >>> logic/lpsc_pkg.sv
package lpsc_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] LPSC_OFS_WAKE_LEVEL = 8'h00;
	localparam logic [7:0] LPSC_OFS_WAKE_EN    = 8'h04;
	localparam logic [7:0] LPSC_OFS_XTAL       = 8'h08;
	localparam logic [7:0] LPSC_OFS_DIR        = 8'h0C;
	localparam logic [7:0] LPSC_OFS_OUTVAL     = 8'h10;
	localparam logic [7:0] LPSC_OFS_DRIVE      = 8'h14;
	localparam logic [7:0] LPSC_OFS_PULL       = 8'h18;
	localparam logic [7:0] LPSC_OFS_MODE       = 8'h1C;
	localparam int         LPSC_ADDR_W         = 8;
	// ------------------------------------------------------------
	// Field widths, reset values and bus encodings
	// ------------------------------------------------------------
	localparam int         LPSC_WAKE_W         = 5;
	localparam int         LPSC_PAD_W          = 3;
	localparam logic [4:0] LPSC_WAKE_EN_RST    = 5'h07;
	localparam logic [4:0] LPSC_WAKE_LEVEL_RST = 5'h00;
	localparam logic       LPSC_XTAL_RST       = 1'h0;
	localparam logic [2:0] LPSC_DIR_RST        = 3'h7;
	localparam logic [2:0] LPSC_OUTVAL_RST     = 3'h0;
	localparam logic [2:0] LPSC_DRIVE_RST      = 3'h0;
	localparam logic [2:0] LPSC_PULL_RST       = 3'h0;
	localparam logic [1:0] LPSC_HTRANS_NONSEQ  = 2'h2;
	localparam logic [2:0] LPSC_HSIZE_WORD     = 3'h2;
	// ------------------------------------------------------------
	// Power modes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		LPSC_MODE_ACTIVE,
		LPSC_MODE_SLEEP,
		LPSC_MODE_STANDBY
	} lpsc_mode_type;
endpackage

// >>> logic/lpsc_pad_if.sv
`timescale 1ns/1ns
interface lpsc_pad_if;
	logic low_power;
	logic wake_en;
	logic dir_in;
	logic out_val;
	logic drive;
	logic pull;
	logic gpio_oe;
	logic gpio_out;
	logic gpio_drive;
	logic gpio_pull;
	logic pad_oe;
	logic pad_out;
	logic pad_drive;
	logic pad_pull;
	modport ctrl (output low_power, wake_en, dir_in, out_val, drive, pull,
		gpio_oe, gpio_out, gpio_drive, gpio_pull,
		input pad_oe, pad_out, pad_drive, pad_pull);
	modport pad (input low_power, wake_en, dir_in, out_val, drive, pull,
		gpio_oe, gpio_out, gpio_drive, gpio_pull,
		output pad_oe, pad_out, pad_drive, pad_pull);
endinterface

// >>> logic/lpsc_pad_mux.sv
`timescale 1ns/1ns
module lpsc_pad_mux (
	lpsc_pad_if.pad p
);
	// ------------------------------------------------------------
	// Pad control select
	// ------------------------------------------------------------
	wire lp_out_sel;
	// Wake pads keep input so the wake level is never fought
	assign lp_out_sel  = ~p.dir_in & ~p.wake_en;
	assign p.pad_oe    = p.low_power ? lp_out_sel : p.gpio_oe;
	assign p.pad_out   = p.low_power ? p.out_val : p.gpio_out;
	assign p.pad_drive = p.low_power ? p.drive : p.gpio_drive;
	assign p.pad_pull  = p.low_power ? p.pull : p.gpio_pull;
endmodule

// >>> logic/lpsc_regs.sv
`timescale 1ns/1ns
module lpsc_regs
	import lpsc_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hready_in,
	output logic      [31:0] hrdata_out,
	output logic             hreadyout_out,
	output logic             hresp_out,
	input  wire logic [4:0]  wake_pad_level_in,
	input  wire logic [2:0]  gpio_oe_in,
	input  wire logic [2:0]  gpio_out_in,
	input  wire logic [2:0]  gpio_drive_in,
	input  wire logic [2:0]  gpio_pull_in,
	output logic             wake_request_out,
	output logic             crystal_freq_bit_out,
	output logic      [2:0]  pad_oe_out,
	output logic      [2:0]  pad_out_out,
	output logic      [2:0]  pad_drive_out,
	output logic      [2:0]  pad_pull_out
);
	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [4:0]         wake_level_reg_r;
	logic [4:0]         wake_enable_mask_r;
	logic               crystal_freq_bit_r;
	logic [2:0]         lowpower_direction_r;
	logic [2:0]         lowpower_output_value_r;
	logic [2:0]         lowpower_drive_strength_r;
	logic [2:0]         lowpower_pull_enable_r;
	lpsc_mode_type      mode_r;
	logic               wr_pend_r;
	logic [7:0]         wr_addr_r;
	logic [31:0]        rdata_nxt;
	// ------------------------------------------------------------
	// AHB-Lite address phase decode
	// ------------------------------------------------------------
	wire                addr_phase;
	wire                low_power;
	wire [7:0]          addr_lo;
	wire                hit_lvl;
	wire                hit_en;
	wire                hit_xt;
	wire                hit_dir;
	wire                hit_out;
	wire                hit_drv;
	wire                hit_pul;
	wire                hit_mode;
	wire [31:0]         mode_word;
	assign addr_phase = hsel_in & hready_in & htrans_in[1];
	assign addr_lo    = haddr_in[LPSC_ADDR_W-1:0];
	assign low_power  = (mode_r != LPSC_MODE_ACTIVE);
	assign hit_lvl    = (wr_addr_r == LPSC_OFS_WAKE_LEVEL);
	assign hit_en     = (wr_addr_r == LPSC_OFS_WAKE_EN);
	assign hit_xt     = (wr_addr_r == LPSC_OFS_XTAL);
	assign hit_dir    = (wr_addr_r == LPSC_OFS_DIR);
	assign hit_out    = (wr_addr_r == LPSC_OFS_OUTVAL);
	assign hit_drv    = (wr_addr_r == LPSC_OFS_DRIVE);
	assign hit_pul    = (wr_addr_r == LPSC_OFS_PULL);
	assign hit_mode   = (wr_addr_r == LPSC_OFS_MODE);
	assign mode_word  = {30'h0, mode_r};
	// Reads decode the address phase so data stands at the next edge
	always_comb begin
		rdata_nxt = 32'h0;
		case (addr_lo)
			LPSC_OFS_WAKE_LEVEL: rdata_nxt = {27'h0, wake_level_reg_r};
			LPSC_OFS_WAKE_EN:    rdata_nxt = {27'h0, wake_enable_mask_r};
			LPSC_OFS_XTAL:       rdata_nxt = {31'h0, crystal_freq_bit_r};
			LPSC_OFS_DIR:        rdata_nxt = {29'h0, lowpower_direction_r};
			LPSC_OFS_OUTVAL:     rdata_nxt = {29'h0, lowpower_output_value_r};
			LPSC_OFS_DRIVE:      rdata_nxt = {29'h0, lowpower_drive_strength_r};
			LPSC_OFS_PULL:       rdata_nxt = {29'h0, lowpower_pull_enable_r};
			LPSC_OFS_MODE:       rdata_nxt = mode_word;
			default:             rdata_nxt = 32'h0;
		endcase
	end
	// ------------------------------------------------------------
	// Bus pipeline
	// ------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			wr_pend_r     <= 1'b0;
			wr_addr_r     <= 8'h00;
			hrdata_out    <= 32'h0;
			hreadyout_out <= 1'b1;
			hresp_out     <= 1'b0;
		end else begin
			wr_pend_r     <= addr_phase & hwrite_in;
			wr_addr_r     <= addr_lo;
			hreadyout_out <= 1'b1;
			hresp_out     <= 1'b0;
			if (addr_phase & ~hwrite_in) begin
				hrdata_out <= rdata_nxt;
			end
		end
	end
	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	// Reserved bits are simply not stored; writers keep them at reset value
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			wake_level_reg_r          <= LPSC_WAKE_LEVEL_RST;
			wake_enable_mask_r        <= LPSC_WAKE_EN_RST;
			crystal_freq_bit_r        <= LPSC_XTAL_RST;
			lowpower_direction_r      <= LPSC_DIR_RST;
			lowpower_output_value_r   <= LPSC_OUTVAL_RST;
			lowpower_drive_strength_r <= LPSC_DRIVE_RST;
			lowpower_pull_enable_r    <= LPSC_PULL_RST;
		end else if (wr_pend_r) begin
			if (hit_lvl) wake_level_reg_r <= hwdata_in[LPSC_WAKE_W-1:0];
			if (hit_en) wake_enable_mask_r <= hwdata_in[LPSC_WAKE_W-1:0];
			if (hit_xt) crystal_freq_bit_r <= hwdata_in[0];
			if (hit_dir) lowpower_direction_r <= hwdata_in[LPSC_PAD_W-1:0];
			if (hit_out) lowpower_output_value_r <= hwdata_in[LPSC_PAD_W-1:0];
			if (hit_drv) lowpower_drive_strength_r <= hwdata_in[LPSC_PAD_W-1:0];
			if (hit_pul) lowpower_pull_enable_r <= hwdata_in[LPSC_PAD_W-1:0];
		end
	end
	// ------------------------------------------------------------
	// Power mode and wake
	// ------------------------------------------------------------
	wire [4:0] wake_match;
	wire       wake_hit;
	assign wake_match = ~(wake_pad_level_in ^ wake_level_reg_r) & wake_enable_mask_r;
	assign wake_hit   = |wake_match;
	// A matching pad returns the block to active; software enters low power
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			mode_r           <= LPSC_MODE_ACTIVE;
			wake_request_out <= 1'b0;
		end else begin
			wake_request_out <= low_power & wake_hit;
			if (low_power & wake_hit) begin
				mode_r <= LPSC_MODE_ACTIVE;
			end else if (wr_pend_r & hit_mode) begin
				case (hwdata_in[1:0])
					2'h1:    mode_r <= LPSC_MODE_SLEEP;
					2'h2:    mode_r <= LPSC_MODE_STANDBY;
					default: mode_r <= LPSC_MODE_ACTIVE;
				endcase
			end
		end
	end
	// ------------------------------------------------------------
	// Pads
	// ------------------------------------------------------------
	logic [2:0] oe_c;
	logic [2:0] out_c;
	logic [2:0] drv_c;
	logic [2:0] pul_c;
	genvar g;
	generate
		for (g = 0; g < LPSC_PAD_W; g++) begin : gen_pad
			lpsc_pad_if pif ();
			assign pif.low_power  = low_power;
			assign pif.wake_en    = wake_enable_mask_r[g];
			assign pif.dir_in     = lowpower_direction_r[g];
			assign pif.out_val    = lowpower_output_value_r[g];
			assign pif.drive      = lowpower_drive_strength_r[g];
			assign pif.pull       = lowpower_pull_enable_r[g];
			assign pif.gpio_oe    = gpio_oe_in[g];
			assign pif.gpio_out   = gpio_out_in[g];
			assign pif.gpio_drive = gpio_drive_in[g];
			assign pif.gpio_pull  = gpio_pull_in[g];
			lpsc_pad_mux u_mux (
				.p (pif.pad)
			);
			assign oe_c[g]  = pif.pad_oe;
			assign out_c[g] = pif.pad_out;
			assign drv_c[g] = pif.pad_drive;
			assign pul_c[g] = pif.pad_pull;
		end
	endgenerate
	// Registered so pads see no decode glitches
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			pad_oe_out    <= 3'h0;
			pad_out_out   <= 3'h0;
			pad_drive_out <= 3'h0;
			pad_pull_out  <= 3'h0;
		end else begin
			pad_oe_out    <= oe_c;
			pad_out_out   <= out_c;
			pad_drive_out <= drv_c;
			pad_pull_out  <= pul_c;
		end
	end
	assign crystal_freq_bit_out = crystal_freq_bit_r;
	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	AST_WAKE_EN_RST: assert property (@(posedge clk_in) $past(reset_in) |-> wake_enable_mask_r == LPSC_WAKE_EN_RST) else $error("wake mask reset");
	AST_XTAL_WR: assert property (@(posedge clk_in) disable iff (reset_in) wr_pend_r && hit_xt |=> crystal_freq_bit_r == $past(hwdata_in[0])) else $error("crystal bit write");
	AST_DIR_RST: assert property (@(posedge clk_in) $past(reset_in) |-> lowpower_direction_r == LPSC_DIR_RST) else $error("direction reset");
	AST_OUT_DRIVE: assert property (@(posedge clk_in) disable iff (reset_in) low_power && !lowpower_direction_r[1] && !wake_enable_mask_r[1] |=> pad_oe_out[1] && pad_out_out[1] == $past(lowpower_output_value_r[1])) else $error("pad out drive");
	AST_OUT_READ: assert property (@(posedge clk_in) disable iff (reset_in) addr_phase && !hwrite_in && addr_lo == LPSC_OFS_OUTVAL |=> hrdata_out == {29'h0, $past(lowpower_output_value_r)}) else $error("output readback");
	AST_DRIVE: assert property (@(posedge clk_in) disable iff (reset_in) low_power |=> pad_drive_out == $past(lowpower_drive_strength_r)) else $error("drive strength");
	AST_PULL: assert property (@(posedge clk_in) disable iff (reset_in) low_power |=> pad_pull_out == $past(lowpower_pull_enable_r)) else $error("pull enable");
	AST_MAP: assert property (@(posedge clk_in) disable iff (reset_in) wr_pend_r && wr_addr_r == LPSC_OFS_PULL |=> lowpower_pull_enable_r == $past(hwdata_in[2:0])) else $error("pull offset");
	AST_WAKE: assert property (@(posedge clk_in) disable iff (reset_in) low_power && wake_hit |=> wake_request_out && mode_r == LPSC_MODE_ACTIVE) else $error("wake request");
	AST_WAKE_DIR: assert property (@(posedge clk_in) disable iff (reset_in) low_power && wake_enable_mask_r[0] |=> !pad_oe_out[0]) else $error("wake pad output");
	AST_ACTIVE: assert property (@(posedge clk_in) disable iff (reset_in) !low_power |=> pad_oe_out == $past(gpio_oe_in)) else $error("gpio passthrough");
endmodule

// >>> dv/lpsc_regs_tb_top.sv
`timescale 1ns/1ns
module lpsc_regs_tb_top;
	import lpsc_pkg::*;
	// ------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------
	logic        clk_in   = 1'b0;
	logic        reset_in = 1'b1;
	logic        hsel     = 1'b0;
	logic [31:0] haddr    = 32'h0;
	logic [1:0]  htrans   = 2'h0;
	logic        hwrite   = 1'b0;
	logic [2:0]  hsize    = 3'h2;
	logic [31:0] hwdata   = 32'h0;
	logic [4:0]  wake_lvl = 5'h00;
	logic [2:0]  g_oe     = 3'h3;
	logic [2:0]  g_out    = 3'h2;
	logic [2:0]  g_drv    = 3'h1;
	logic [2:0]  g_pull   = 3'h4;
	logic [31:0] hrdata;
	logic        hready;
	logic        hresp;
	logic        wake_req;
	logic        xtal;
	logic [2:0]  p_oe;
	logic [2:0]  p_out;
	logic [2:0]  p_drv;
	logic [2:0]  p_pull;
	logic [31:0] rd;
	int          error_cnt = 0;
	int          tests_run = 0;
	// Offsets 0x00 to 0x18, then the unmapped word 0x20; the mode register at 0x1C is not in the list
	logic [7:0]  ofs [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20};
	logic [31:0] rstv [8] = '{32'h0, 32'h7, 32'h0, 32'h7, 32'h0, 32'h0, 32'h0, 32'h0};
	// Write values keep every reserved bit of the mapped registers at zero; the unmapped word 0x20 is written with 3
	logic [31:0] wv [8] = '{32'h1F, 32'h19, 32'h1, 32'h2, 32'h5, 32'h6, 32'h3, 32'h3};

	always #5 clk_in = ~clk_in;

	lpsc_regs dut (
		.clk_in               (clk_in),
		.reset_in             (reset_in),
		.hsel_in              (hsel),
		.haddr_in             (haddr),
		.htrans_in            (htrans),
		.hwrite_in            (hwrite),
		.hsize_in             (hsize),
		.hwdata_in            (hwdata),
		.hready_in            (hready),
		.hrdata_out           (hrdata),
		.hreadyout_out        (hready),
		.hresp_out            (hresp),
		.wake_pad_level_in    (wake_lvl),
		.gpio_oe_in           (g_oe),
		.gpio_out_in          (g_out),
		.gpio_drive_in        (g_drv),
		.gpio_pull_in         (g_pull),
		.wake_request_out     (wake_req),
		.crystal_freq_bit_out (xtal),
		.pad_oe_out           (p_oe),
		.pad_out_out          (p_out),
		.pad_drive_out        (p_drv),
		.pad_pull_out         (p_pull)
	);
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Holds each phase until hready is seen high; no fixed latency assumed
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk_in);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= LPSC_HTRANS_NONSEQ;
		hwrite <= wr;
		hsize  <= LPSC_HSIZE_WORD;
		@(posedge clk_in);
		while (hready !== 1'b1) @(posedge clk_in);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge clk_in);
		while (hready !== 1'b1) @(posedge clk_in);
		rd = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask

	task automatic pads(input logic [2:0] oe, input logic [2:0] om, input logic [2:0] ov,
		input logic [2:0] dv, input logic [2:0] pv);
		chk("pad_oe", {29'h0, oe}, {29'h0, p_oe});
		chk("pad_out", {29'h0, ov & om}, {29'h0, p_out & om});
		chk("pad_drive", {29'h0, dv}, {29'h0, p_drv});
		chk("pad_pull", {29'h0, pv}, {29'h0, p_pull});
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		chk("xtal_out", 32'h0, {31'h0, xtal});
		for (int i = 0; i < 8; i++) begin
			bus(1'b0, ofs[i], 32'h0);
			chk("reset_read", rstv[i], rd);
		end
		$display("test reset values done");
	endtask

	task automatic t_rw;
		for (int i = 0; i < 8; i++) bus(1'b1, ofs[i], wv[i]);
		for (int i = 0; i < 8; i++) begin
			bus(1'b0, ofs[i], 32'h0);
			chk("readback", (i == 7) ? 32'h0 : wv[i], rd);
		end
		chk("xtal_out", 32'h1, {31'h0, xtal});
		pads(g_oe, 3'h7, g_out, g_drv, g_pull);
		$display("test write readback done");
	endtask

	// Sleep pads: pad0 wake-enabled so forced input, pad2 drives its value
	task automatic t_sleep(input logic [1:0] m);
		int n;
		n = 0;
		bus(1'b1, LPSC_OFS_MODE, {30'h0, m});
		repeat (3) @(posedge clk_in);
		pads(3'h4, 3'h4, 3'h5, 3'h6, 3'h3);
		bus(1'b0, LPSC_OFS_MODE, 32'h0);
		chk("mode_low_power", {30'h0, m}, rd);
		wake_lvl <= 5'h02;
		repeat (4) @(posedge clk_in);
		bus(1'b0, LPSC_OFS_MODE, 32'h0);
		chk("mode_masked_pad", {30'h0, m}, rd);
		wake_lvl <= 5'h0A;
		repeat (8) begin
			@(negedge clk_in);
			n += (wake_req === 1'b1) ? 1 : 0;
		end
		chk("wake_pulses", 32'h1, n);
		bus(1'b0, LPSC_OFS_MODE, 32'h0);
		chk("mode_after_wake", {30'h0, LPSC_MODE_ACTIVE}, rd);
		pads(g_oe, 3'h7, g_out, g_drv, g_pull);
		wake_lvl <= 5'h00;
		$display("test low power mode %0d done", m);
	endtask
	// ------------------------------------------------------------
	// Sequence, watchdog and verdict
	// ------------------------------------------------------------
	task automatic wrap_up;
		$display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge clk_in);
		reset_in <= 1'b0;
		t_reset();
		t_rw();
		t_sleep(LPSC_MODE_SLEEP);
		t_sleep(LPSC_MODE_STANDBY);
		wrap_up();
	end

	// Whole run is about 130 cycles; generous margin for slow answers
	initial begin
		#100000;
		error_cnt++;
		wrap_up();
	end
endmodule
